// >>> rdt_pkg.sv
/*
 * rdt_pkg: constants shared by the resonant-mode edge timing block for the third
 * and fourth pwm outputs (register offsets, reset values, field positions, timing).
 * assumes: 40 MHz controller clock, register port with 8-bit address and data.
 */
package rdt_pkg;
    // register offsets
    localparam logic [7:0] OFS_THIRD_OUTPUT_FALL_LEAD = 8'h4b;
    localparam logic [7:0] OFS_FOURTH_OUTPUT_RISE_OFFSET = 8'h4d;
    localparam logic [7:0] OFS_FOURTH_OUTPUT_FALL_LEAD = 8'h4f;
    localparam logic [7:0] OFS_EDGE_STATUS = 8'h50;
    // reset values
    localparam logic [7:0] RST_THIRD_OUTPUT_FALL_LEAD = 8'h00;
    localparam logic [7:0] RST_FOURTH_OUTPUT_RISE_OFFSET = 8'h00;
    localparam logic [7:0] RST_FOURTH_OUTPUT_FALL_LEAD = 8'h00;
    // status fields
    localparam int STS_THIRD_BIT = 0;
    localparam int STS_FOURTH_BIT = 1;
    localparam int STS_RUNNING_BIT = 2;
    // rise offset code: bit 7 set means leading, lead = 256 - code steps
    localparam int OFFSET_LEAD_BIT = 7;
    localparam logic [8:0] OFFSET_LEAD_BASE = 9'h100;
    // timing: code step and clock period in ns, steps per clock derived
    localparam int STEP_NS = 5;
    localparam int CLK_PERIOD_NS = 25;
    localparam logic [8:0] STEPS_PER_CLK = 9'(CLK_PERIOD_NS / STEP_NS);
    localparam int CYCLE_W = 16;
endpackage : rdt_pkg

// >>> rdt_step_to_cycles.sv
/*
 * rdt_step_to_cycles: converts a count of 5 ns steps into whole controller clocks.
 * assumes: purely combinational, used by rdt_resonant_dead_time_cd.
 */
`timescale 1ns/1ps
module rdt_step_to_cycles
    import rdt_pkg::*;
(
    input wire logic [8:0] steps,
    output logic [CYCLE_W-1:0] cycles
);
    // rounds down: a clock is 5 steps, finer residue cannot be placed on a 25 ns grid
    logic [8:0] quot;
    assign quot = steps / STEPS_PER_CLK;
    assign cycles = {{(CYCLE_W-9){1'b0}}, quot};
endmodule : rdt_step_to_cycles

// >>> rdt_resonant_dead_time_cd.sv
/*
 * rdt_resonant_dead_time_cd: resonant-mode edge placement for the third and fourth
 * pwm outputs, with the three timing registers and a status register.
 * assumes: cycle_start, cycle_len and resonant_mode come from the switching cycle
 * generator on mclk; cycle_len is the length of the starting cycle in clocks.
 */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module rdt_resonant_dead_time_cd
    import rdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic resonant_mode,
    input wire logic cycle_start,
    input wire logic [CYCLE_W-1:0] cycle_len,
    input wire logic [CYCLE_W-1:0] third_rise_cycles,
    output logic third_pwm_output,
    output logic fourth_pwm_output
);
    typedef struct packed {
        logic [7:0] third_output_fall_lead;
        logic [7:0] fourth_output_rise_offset;
        logic [7:0] fourth_output_fall_lead;
        logic [7:0] act_third_fall;
        logic [7:0] act_fourth_rise;
        logic [7:0] act_fourth_fall;
        logic [CYCLE_W-1:0] act_third_rise;
        logic [CYCLE_W-1:0] pos;
        logic [CYCLE_W-1:0] len;
        logic running;
        logic [7:0] rdata;
        logic third_out;
        logic fourth_out;
    } rdt_state_t;

    localparam rdt_state_t RST_STATE = '{
        third_output_fall_lead: RST_THIRD_OUTPUT_FALL_LEAD,
        fourth_output_rise_offset: RST_FOURTH_OUTPUT_RISE_OFFSET,
        fourth_output_fall_lead: RST_FOURTH_OUTPUT_FALL_LEAD,
        act_third_fall: RST_THIRD_OUTPUT_FALL_LEAD,
        act_fourth_rise: RST_FOURTH_OUTPUT_RISE_OFFSET,
        act_fourth_fall: RST_FOURTH_OUTPUT_FALL_LEAD,
        default: '0
    };

    rdt_state_t s;
    rdt_state_t next_s;

    logic [8:0] third_fall_steps;
    logic [8:0] fourth_fall_steps;
    logic [8:0] fourth_rise_steps;
    logic [CYCLE_W-1:0] third_fall_cyc;
    logic [CYCLE_W-1:0] fourth_fall_cyc;
    logic [CYCLE_W-1:0] fourth_rise_cyc;

    assign third_fall_steps = {1'b0, s.act_third_fall};
    assign fourth_fall_steps = {1'b0, s.act_fourth_fall};

    // magnitude of the rise offset: trailing codes as is, leading codes 256 - code
    always_comb
    begin
        if (s.act_fourth_rise[OFFSET_LEAD_BIT])
        begin
            fourth_rise_steps = OFFSET_LEAD_BASE - {1'b0, s.act_fourth_rise};
        end
        else
        begin
            fourth_rise_steps = {1'b0, s.act_fourth_rise};
        end
    end

    rdt_step_to_cycles u_third_fall (
        .steps(third_fall_steps),
        .cycles(third_fall_cyc)
    );

    rdt_step_to_cycles u_fourth_fall (
        .steps(fourth_fall_steps),
        .cycles(fourth_fall_cyc)
    );

    rdt_step_to_cycles u_fourth_rise (
        .steps(fourth_rise_steps),
        .cycles(fourth_rise_cyc)
    );

    logic [CYCLE_W-1:0] mid;
    logic [CYCLE_W:0] fourth_rise_pos;
    logic [CYCLE_W:0] third_fall_chk;
    logic [CYCLE_W:0] fourth_fall_chk;
    logic third_on;
    logic fourth_on;

    always_comb
    begin
        mid = s.len >> 1;
        if (s.act_fourth_rise[OFFSET_LEAD_BIT])
        begin
            // a lead longer than half the cycle clamps to the cycle start
            if (mid >= fourth_rise_cyc)
            begin
                fourth_rise_pos = {1'b0, mid - fourth_rise_cyc};
            end
            else
            begin
                fourth_rise_pos = '0;
            end
        end
        else
        begin
            fourth_rise_pos = {1'b0, mid} + {1'b0, fourth_rise_cyc};
        end
        // output is high while pos + lead is still short of the cycle end
        third_fall_chk = {1'b0, s.pos} + {1'b0, third_fall_cyc};
        fourth_fall_chk = {1'b0, s.pos} + {1'b0, fourth_fall_cyc};
        third_on = s.running && (s.pos >= s.act_third_rise)
            && (third_fall_chk < {1'b0, s.len});
        fourth_on = s.running && ({1'b0, s.pos} >= fourth_rise_pos)
            && (fourth_fall_chk < {1'b0, s.len});
    end

    always_comb
    begin
        next_s = s;
        next_s.rdata = 8'h00;
        next_s.third_out = third_on;
        next_s.fourth_out = fourth_on;

        if (wr_en)
        begin
            case (addr)
                OFS_THIRD_OUTPUT_FALL_LEAD: next_s.third_output_fall_lead = wdata;
                OFS_FOURTH_OUTPUT_RISE_OFFSET: next_s.fourth_output_rise_offset = wdata;
                OFS_FOURTH_OUTPUT_FALL_LEAD: next_s.fourth_output_fall_lead = wdata;
                default: next_s.rdata = 8'h00;
            endcase
        end

        if (rd_en)
        begin
            case (addr)
                OFS_THIRD_OUTPUT_FALL_LEAD: next_s.rdata = s.third_output_fall_lead;
                OFS_FOURTH_OUTPUT_RISE_OFFSET: next_s.rdata = s.fourth_output_rise_offset;
                OFS_FOURTH_OUTPUT_FALL_LEAD: next_s.rdata = s.fourth_output_fall_lead;
                OFS_EDGE_STATUS:
                begin
                    next_s.rdata[STS_THIRD_BIT] = s.third_out;
                    next_s.rdata[STS_FOURTH_BIT] = s.fourth_out;
                    next_s.rdata[STS_RUNNING_BIT] = s.running;
                end
                default: next_s.rdata = 8'h00;
            endcase
        end

        if (!resonant_mode)
        begin
            // leaving resonant mode drops both outputs at once, no cycle completion
            next_s.running = 1'b0;
            next_s.pos = '0;
            next_s.third_out = 1'b0;
            next_s.fourth_out = 1'b0;
        end
        else if (cycle_start)
        begin
            // a write in this same cycle is already visible to the new cycle
            next_s.running = 1'b1;
            next_s.pos = '0;
            next_s.len = cycle_len;
            next_s.act_third_rise = third_rise_cycles;
            next_s.act_third_fall = next_s.third_output_fall_lead;
            next_s.act_fourth_rise = next_s.fourth_output_rise_offset;
            next_s.act_fourth_fall = next_s.fourth_output_fall_lead;
        end
        else if (s.running && (s.pos != {CYCLE_W{1'b1}}))
        begin
            next_s.pos = s.pos + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= RST_STATE;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign third_pwm_output = s.third_out;
    assign fourth_pwm_output = s.fourth_out;
endmodule : rdt_resonant_dead_time_cd

// >>> rdt_sva.sv
/* rdt_sva: port checker for rdt_resonant_dead_time_cd.
   assumes: bound from tb, a single mclk domain. */
`timescale 1ns/1ps
module rdt_sva
    import rdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic resonant_mode,
    input wire logic cycle_start,
    input wire logic [CYCLE_W-1:0] cycle_len,
    input wire logic [CYCLE_W-1:0] third_rise_cycles,
    input wire logic third_pwm_output,
    input wire logic fourth_pwm_output
);
    // position mirror: output for position p is sampled while cnt == p+1
    logic [CYCLE_W-1:0] cnt;
    logic [CYCLE_W-1:0] len;
    logic [CYCLE_W-1:0] rise3;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= '1;
            len <= '0;
            rise3 <= '0;
        end
        else if (cycle_start && resonant_mode)
        begin
            cnt <= '0;
            len <= cycle_len;
            rise3 <= third_rise_cycles;
        end
        else if (cnt != '1)
        begin
            cnt <= cnt + 1'b1;
        end
    end
    // widest lead from the midpoint is 640 ns and widest trail 635 ns, placed on whole clocks only
    localparam logic [CYCLE_W-1:0] RISE_SPAN = CYCLE_W'((OFFSET_LEAD_BASE >> 1) / STEPS_PER_CLK);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_rd_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data outside its slot");
    a_rd_unmapped: assert property ($past(rd_en) && $past(addr) == 8'h4c |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mode_off: assert property (!resonant_mode |=> !third_pwm_output && !fourth_pwm_output)
        else $error("outputs active outside resonant mode");
    a_cycle_end: assert property (cnt == len + 1'b1 |-> !third_pwm_output && !fourth_pwm_output)
        else $error("output high at cycle end");
    a_third_rise: assert property ($rose(third_pwm_output) |-> cnt == rise3 + 1'b1)
        else $error("third output rose at wrong position");
    a_fourth_rise: assert property ($rose(fourth_pwm_output) |->
        (cnt + RISE_SPAN > (len >> 1)) && (cnt <= (len >> 1) + RISE_SPAN + 1'b1))
        else $error("fourth output rose outside the midpoint window");
endmodule : rdt_sva

// >>> rdt_drv_model.sv
/* rdt_drv_model: power stage driver model, integrates gate on-time per cycle.
   assumes: cycle_start is the same pulse the block sees. */
`timescale 1ns/1ps
module rdt_drv_model (
    input wire logic mclk,
    input wire logic cycle_start,
    input wire logic gate_c,
    input wire logic gate_d,
    output integer on_c,
    output integer on_d
);
    // on-time alone pins the rise once the fall is known, so no edge log is kept
    // four-state sums so that an unknown gate level spoils the count instead of adding zero
    always @(posedge mclk)
    begin
        on_c <= cycle_start ? 0 : on_c + gate_c;
        on_d <= cycle_start ? 0 : on_d + gate_d;
    end
endmodule : rdt_drv_model

// >>> tb.sv
/* tb: register and edge timing tests for rdt_resonant_dead_time_cd.
   assumes: rdt_pkg, rdt_sva and rdt_drv_model are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; $display("mismatch at %0t: %0h vs %0h", $time, g, e); end end
module tb
    import rdt_pkg::*;
;
    logic mclk = 0, rst_n = 0, wr_en = 0, rd_en = 0, resonant_mode = 0, cycle_start = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [CYCLE_W-1:0] cycle_len = '0, third_rise_cycles = '0;
    logic third_pwm_output, fourth_pwm_output;
    int err_count = 0, n_compared = 0;
    integer on_c, on_d;
    always #12.5 mclk = ~mclk;
    rdt_resonant_dead_time_cd rdt_resonant_dead_time_cd_i (.mclk(mclk), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .resonant_mode(resonant_mode), .cycle_start(cycle_start), .cycle_len(cycle_len),
        .third_rise_cycles(third_rise_cycles), .third_pwm_output(third_pwm_output),
        .fourth_pwm_output(fourth_pwm_output));
    rdt_drv_model rdt_drv_model_i (.mclk(mclk), .cycle_start(cycle_start),
        .gate_c(third_pwm_output), .gate_d(fourth_pwm_output), .on_c(on_c), .on_d(on_d));
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        @(negedge mclk);
        `CHK(rdata, e)
        @(posedge mclk);
    endtask : rd
    function automatic int hi(input int x);
        return x < 0 ? 0 : x;
    endfunction : hi
    // the mid-cycle write must not reach the running cycle
    task automatic run(input logic [7:0] l3, c4, l4, input int r3);
        int len;
        int e4;
        len = 300;
        wr(OFS_THIRD_OUTPUT_FALL_LEAD, l3);
        wr(OFS_FOURTH_OUTPUT_RISE_OFFSET, c4);
        wr(OFS_FOURTH_OUTPUT_FALL_LEAD, l4);
        cycle_len <= 16'(len);
        third_rise_cycles <= 16'(r3);
        cycle_start <= 1'b1;
        @(posedge mclk);
        cycle_start <= 1'b0;
        wr(OFS_THIRD_OUTPUT_FALL_LEAD, ~l3);
        repeat (len + 4) @(posedge mclk);
        e4 = c4[7] ? len / 2 - (256 - c4) / 5 : len / 2 + c4 / 5;
        @(negedge mclk);
        `CHK(on_c, hi(len - l3 / 5 - r3))
        `CHK(on_d, hi(len - l4 / 5 - e4))
        @(posedge mclk);
        rd(OFS_EDGE_STATUS, 8'(1 << STS_RUNNING_BIT));
    endtask : run
    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(OFS_THIRD_OUTPUT_FALL_LEAD, RST_THIRD_OUTPUT_FALL_LEAD);
        rd(OFS_FOURTH_OUTPUT_RISE_OFFSET, RST_FOURTH_OUTPUT_RISE_OFFSET);
        rd(OFS_FOURTH_OUTPUT_FALL_LEAD, RST_FOURTH_OUTPUT_FALL_LEAD);
        wr(OFS_FOURTH_OUTPUT_RISE_OFFSET, 8'ha5);
        rd(OFS_FOURTH_OUTPUT_RISE_OFFSET, 8'ha5);
        wr(OFS_EDGE_STATUS, 8'hff);
        rd(OFS_EDGE_STATUS, 8'h00);
        rd(8'h4c, 8'h00);
        resonant_mode <= 1'b1;
        run(8'h00, 8'h00, 8'h00, 0);
        run(8'hff, 8'h7f, 8'hff, 10);
        run(8'h0a, 8'h80, 8'h05, 3);
        run(8'h09, 8'hff, 8'h04, 0);
        // third lead now holds the mid-cycle write, so the third output is high early on
        cycle_start <= 1'b1;
        @(posedge mclk);
        cycle_start <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(OFS_EDGE_STATUS, 8'((1 << STS_RUNNING_BIT) | (1 << STS_THIRD_BIT)));
        resonant_mode <= 1'b0;
        @(posedge mclk);
        rd(OFS_EDGE_STATUS, 8'h00);
        // reset in the middle of a running cycle
        resonant_mode <= 1'b1;
        cycle_start <= 1'b1;
        @(posedge mclk);
        cycle_start <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(OFS_THIRD_OUTPUT_FALL_LEAD, RST_THIRD_OUTPUT_FALL_LEAD);
        rd(OFS_EDGE_STATUS, 8'h00);
        complete_run();
    end
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        complete_run();
    end
endmodule : tb
bind rdt_resonant_dead_time_cd rdt_sva rdt_sva_i (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .rd_en(rd_en), .rdata(rdata), .resonant_mode(resonant_mode), .cycle_start(cycle_start),
    .cycle_len(cycle_len), .third_rise_cycles(third_rise_cycles),
    .third_pwm_output(third_pwm_output), .fourth_pwm_output(fourth_pwm_output));
